// File: core/sfac_spi_host.sv
/*
  Host controller for a serial non-volatile memory: APB register slave,
  command sequencer and SPI mode 0 pins.
  Assumes one 40 MHz clock, synchronous reset and a device on the pins.
*/
`timescale 1ns/10ps
`include "sfac_params.svh"
// Functional notes
// - Array write is preceded by its own write-enable frame, chip select cycled.
// - Array write sends 02h then three address bytes, MSB first.
// - Each write byte takes eight clocks, MSB first.
// - Array read sends 03h and address; data follows on next clocks.
// - Quick read sends 0Bh, address, one dummy byte, then reads.
// - Quick-read dummy byte avoids upper nibble 1010; 00h is used.
// - Sector write is preceded by its own write-enable frame.
// - Sector write sends 42h and address; only low 8 bits count.
// - Sector access ends with chip select after the last sector byte.
// - Sector read sends 4Bh and address, then streams bytes.
module sfac_spi_host #(
  parameter int unsigned SCK_HALF = `SFAC_SCK_HALF,
  parameter int unsigned AW       = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // APB slave
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic               pready_o,
  output logic [31:0]        prdata_o,
  output logic               pslverr_o,
  // Serial memory pins
  output logic               cs_n_o,
  output logic               sck_o,
  output logic               mosi_o,
  input  wire logic          miso_i
);

  if (AW < 5 || AW > 32) begin
    $error("sfac_spi_host: AW must lie in 5..32");
  end

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned GAP_RAW =
    (`SFAC_CS_HIGH_NS * `SFAC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] GAP_CYC = 8'((GAP_RAW < 1) ? 1 : GAP_RAW);

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic [7:0] ofs;
  logic       acc, wr_acc, rd_acc, hit;

  assign ofs    = 8'(paddr_i);
  assign acc    = psel_i & penable_i & pready_o;
  assign wr_acc = acc & pwrite_i;
  assign rd_acc = acc & ~pwrite_i;
  assign hit    = (paddr_i >> 5) == '0 &&
                  (ofs == `SFAC_OFS_CMD || ofs == `SFAC_OFS_ADDR ||
                   ofs == `SFAC_OFS_TXD || ofs == `SFAC_OFS_RXD ||
                   ofs == `SFAC_OFS_STAT);

  // ************************************************************
  // Sequencer state
  // ************************************************************
  sfac_pkg::sfac_state_t    state_ff, nxt_state;
  sfac_pkg::sfac_kind_t     kind_ff, nxt_kind, wr_kind;
  sfac_pkg::sfac_byte_req_t req;
  sfac_pkg::sfac_pins_t     pins;
  logic [23:0] addr_ff, nxt_addr;
  logic [23:0] areg_ff, nxt_areg;
  logic [15:0] left_ff, nxt_left;
  logic [2:0]  hidx_ff, nxt_hidx;
  logic [7:0]  gap_ff, nxt_gap;
  logic [7:0]  tx_ff, nxt_tx;
  logic [7:0]  rx_ff, nxt_rx;
  logic        txv_ff, nxt_txv;
  logic        rxv_ff, nxt_rxv;
  logic        err_ff, nxt_err;
  logic        abort_ff, nxt_abort;
  logic        fin_ff, nxt_fin;
  logic        fly_ff, nxt_fly;
  logic        cs_n_ff, nxt_cs_n;
  logic        done;
  logic [7:0]  rx_byte;
  logic        miso_s;
  logic        is_wr, is_sec;
  logic [2:0]  hlast;
  logic [7:0]  hbyte, opcode;

  assign wr_kind = sfac_pkg::sfac_kind_t'(pwdata_i[`SFAC_CMD_KIND_LSB +: 3]);
  assign is_wr   = kind_ff == sfac_pkg::SFAC_K_WRITE || kind_ff == sfac_pkg::SFAC_K_SECWR;
  assign is_sec  = kind_ff == sfac_pkg::SFAC_K_SECWR || kind_ff == sfac_pkg::SFAC_K_SECRD;

  // Header bytes: opcode, address MSB first, optional dummy
  always_comb begin
    opcode = `SFAC_OP_SET_WL;
    hlast  = 3'h3;
    unique case (kind_ff)
      sfac_pkg::SFAC_K_SETWL: hlast = 3'h0;
      sfac_pkg::SFAC_K_WRITE: opcode = `SFAC_OP_WRITE;
      sfac_pkg::SFAC_K_READ:  opcode = `SFAC_OP_READ;
      sfac_pkg::SFAC_K_QREAD: begin
        opcode = `SFAC_OP_QREAD;
        hlast  = 3'h4;
      end
      sfac_pkg::SFAC_K_SECWR: opcode = `SFAC_OP_SECWR;
      sfac_pkg::SFAC_K_SECRD: opcode = `SFAC_OP_SECRD;
      sfac_pkg::SFAC_K_IDRD: begin
        opcode = `SFAC_OP_IDRD;
        hlast  = 3'h0;
      end
      default: hlast = 3'h0;
    endcase
    unique case (hidx_ff)
      3'h0:    hbyte = opcode;
      3'h1:    hbyte = addr_ff[23:16];
      3'h2:    hbyte = addr_ff[15:8];
      3'h3:    hbyte = addr_ff[7:0];
      default: hbyte = `SFAC_DUMMY;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_kind  = kind_ff;
    nxt_addr  = addr_ff;
    nxt_areg  = areg_ff;
    nxt_left  = left_ff;
    nxt_hidx  = hidx_ff;
    nxt_gap   = gap_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    nxt_txv   = txv_ff;
    nxt_rxv   = rxv_ff;
    nxt_err   = err_ff;
    nxt_abort = abort_ff;
    nxt_fin   = fin_ff;
    nxt_fly   = fly_ff;
    nxt_cs_n  = cs_n_ff;
    req.start = 1'b0;
    req.data  = 8'h00;
    // Software side: clears first, so hardware sets below win
    if (rd_acc && ofs == `SFAC_OFS_RXD) begin
      nxt_rxv = 1'b0;
    end
    if (wr_acc && ofs == `SFAC_OFS_STAT && pwdata_i[`SFAC_ST_ERR]) begin
      nxt_err = 1'b0;
    end
    if (wr_acc && ofs == `SFAC_OFS_ADDR) begin
      nxt_areg = pwdata_i[23:0];
    end
    if (wr_acc && ofs == `SFAC_OFS_TXD) begin
      nxt_tx  = pwdata_i[7:0];
      nxt_txv = 1'b1;
    end
    if (wr_acc && ofs == `SFAC_OFS_CMD && state_ff != sfac_pkg::SFAC_SQ_IDLE) begin
      nxt_abort = nxt_abort | pwdata_i[`SFAC_CMD_ABORT];
      nxt_err   = ~pwdata_i[`SFAC_CMD_ABORT] | nxt_err;
    end
    unique case (state_ff)
      sfac_pkg::SFAC_SQ_IDLE: begin
        nxt_abort = 1'b0;
        if (wr_acc && ofs == `SFAC_OFS_CMD) begin
          if (wr_kind == sfac_pkg::SFAC_K_BAD) begin
            nxt_err = 1'b1;
          end else begin
            nxt_kind = wr_kind;
            nxt_hidx = 3'h0;
            nxt_fin  = 1'b0;
            nxt_cs_n = 1'b0;
            nxt_left = pwdata_i[`SFAC_CMD_LEN_LSB +: 16];
            nxt_addr = areg_ff & `SFAC_ARRAY_MASK;
            if (wr_kind == sfac_pkg::SFAC_K_SECWR || wr_kind == sfac_pkg::SFAC_K_SECRD) begin
              nxt_addr = areg_ff & `SFAC_SECTOR_MASK;
            end
            if (wr_kind == sfac_pkg::SFAC_K_IDRD) begin
              nxt_left = `SFAC_ID_BYTES;
            end
            if (wr_kind == sfac_pkg::SFAC_K_SETWL) begin
              nxt_left = 16'h0000;
            end
            if (wr_kind == sfac_pkg::SFAC_K_WRITE || wr_kind == sfac_pkg::SFAC_K_SECWR) begin
              nxt_state = sfac_pkg::SFAC_SQ_WEN;
            end else begin
              nxt_state = sfac_pkg::SFAC_SQ_HDR;
            end
          end
        end
      end
      sfac_pkg::SFAC_SQ_WEN: begin
        if (!fly_ff) begin
          req.start = 1'b1;
          req.data  = `SFAC_OP_SET_WL;
          nxt_fly   = 1'b1;
        end else if (done) begin
          nxt_fly   = 1'b0;
          nxt_cs_n  = 1'b1;
          nxt_gap   = GAP_CYC;
          nxt_state = sfac_pkg::SFAC_SQ_GAP;
        end
      end
      sfac_pkg::SFAC_SQ_GAP: begin
        // Chip select stays high long enough to end the frame cleanly
        if (gap_ff > 8'h01) begin
          nxt_gap = gap_ff - 8'h01;
        end else if (fin_ff) begin
          nxt_state = sfac_pkg::SFAC_SQ_IDLE;
        end else begin
          nxt_cs_n  = 1'b0;
          nxt_state = sfac_pkg::SFAC_SQ_HDR;
        end
      end
      sfac_pkg::SFAC_SQ_HDR: begin
        if (!fly_ff) begin
          req.start = 1'b1;
          req.data  = hbyte;
          nxt_fly   = 1'b1;
        end else if (done) begin
          nxt_fly = 1'b0;
          if (hidx_ff == hlast) begin
            nxt_state = sfac_pkg::SFAC_SQ_DATA;
          end else begin
            nxt_hidx = hidx_ff + 3'h1;
          end
        end
      end
      sfac_pkg::SFAC_SQ_DATA: begin
        if (fly_ff) begin
          if (done) begin
            nxt_fly  = 1'b0;
            nxt_left = left_ff - 16'h0001;
            if (!is_wr) begin
              nxt_rx  = rx_byte;
              nxt_rxv = 1'b1;
            end
            // Mirror of the device's own counter
            if (is_sec) begin
              nxt_addr = {16'h0000, addr_ff[7:0] + 8'h01};
              if (addr_ff[7:0] == 8'hFF) begin
                nxt_left = 16'h0000;
              end
            end else begin
              nxt_addr = {4'h0, addr_ff[19:0] + 20'h00001};
            end
          end
        end else if (left_ff == 16'h0000 || abort_ff) begin
          // Frame ends only between bytes, never inside one
          nxt_cs_n  = 1'b1;
          nxt_fin   = 1'b1;
          nxt_gap   = GAP_CYC;
          nxt_state = sfac_pkg::SFAC_SQ_GAP;
        end else if (is_wr) begin
          if (txv_ff) begin
            req.start = 1'b1;
            req.data  = tx_ff;
            // A byte written in this very cycle stays pending
            nxt_txv   = wr_acc && ofs == `SFAC_OFS_TXD;
            nxt_fly   = 1'b1;
          end
        end else if (!rxv_ff) begin
          // Filler on the input while the device talks
          req.start = 1'b1;
          req.data  = `SFAC_DUMMY;
          nxt_fly   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= sfac_pkg::SFAC_SQ_IDLE;
      kind_ff  <= sfac_pkg::SFAC_K_SETWL;
      addr_ff  <= `SFAC_RST_ADDR;
      areg_ff  <= `SFAC_RST_ADDR;
      left_ff  <= 16'h0000;
      hidx_ff  <= 3'h0;
      gap_ff   <= 8'h00;
      tx_ff    <= 8'h00;
      rx_ff    <= 8'h00;
      txv_ff   <= 1'b0;
      rxv_ff   <= 1'b0;
      err_ff   <= 1'b0;
      abort_ff <= 1'b0;
      fin_ff   <= 1'b0;
      fly_ff   <= 1'b0;
      cs_n_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      kind_ff  <= nxt_kind;
      addr_ff  <= nxt_addr;
      areg_ff  <= nxt_areg;
      left_ff  <= nxt_left;
      hidx_ff  <= nxt_hidx;
      gap_ff   <= nxt_gap;
      tx_ff    <= nxt_tx;
      rx_ff    <= nxt_rx;
      txv_ff   <= nxt_txv;
      rxv_ff   <= nxt_rxv;
      err_ff   <= nxt_err;
      abort_ff <= nxt_abort;
      fin_ff   <= nxt_fin;
      fly_ff   <= nxt_fly;
      cs_n_ff  <= nxt_cs_n;
    end
  end

  // ************************************************************
  // Bus answer: one wait state so every output comes from a flop
  // ************************************************************
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;

  always_comb begin
    nxt_pready  = psel_i & penable_i & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (nxt_pready) begin
      nxt_pslverr = ~hit;
      nxt_prdata  = 32'h0000_0000;
      if (!pwrite_i && hit) begin
        unique case (ofs)
          `SFAC_OFS_CMD:  nxt_prdata = {left_ff, 13'h0000, kind_ff};
          `SFAC_OFS_ADDR: nxt_prdata = {8'h00, areg_ff};
          `SFAC_OFS_TXD:  nxt_prdata = {24'h000000, tx_ff};
          `SFAC_OFS_RXD:  nxt_prdata = {24'h000000, rx_ff};
          default: begin
            nxt_prdata[`SFAC_ST_BUSY] = state_ff != sfac_pkg::SFAC_SQ_IDLE;
            nxt_prdata[`SFAC_ST_TXE]  = ~txv_ff;
            nxt_prdata[`SFAC_ST_RXV]  = rxv_ff;
            nxt_prdata[`SFAC_ST_ERR]  = err_ff;
            nxt_prdata[`SFAC_ST_LEFT_LSB +: 16] = left_ff;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // ************************************************************
  // Serial engine
  // ************************************************************
  sfac_sync #(
    .W (1)
  ) u_miso_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (miso_i),
    .q_o     (miso_s)
  );

  sfac_byte_shift #(
    .HALF (SCK_HALF)
  ) u_shift (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .req_i   (req),
    .done_o  (done),
    .rx_o    (rx_byte),
    .miso_i  (miso_s),
    .sck_o   (pins.sck),
    .mosi_o  (pins.mosi)
  );

  assign pins.cs_n = cs_n_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign prdata_o  = prdata_ff;
  assign cs_n_o    = pins.cs_n;
  assign sck_o     = pins.sck;
  assign mosi_o    = pins.mosi;

endmodule

// File: inc/sfac_params.svh
/*
  Constants of the serial memory access controller: register offsets,
  field positions, opcodes and timing counts.
  Assumes a 40 MHz system clock and a device answering in SPI mode 0.
*/
`ifndef SFAC_PARAMS_SVH
`define SFAC_PARAMS_SVH

// ************************************************************
// Register offsets (byte addresses, one word each)
// ************************************************************
`define SFAC_OFS_CMD      8'h00
`define SFAC_OFS_ADDR     8'h04
`define SFAC_OFS_TXD      8'h08
`define SFAC_OFS_RXD      8'h0C
`define SFAC_OFS_STAT     8'h10

// ************************************************************
// Field positions
// ************************************************************
`define SFAC_CMD_KIND_LSB 0
`define SFAC_CMD_ABORT    4
`define SFAC_CMD_LEN_LSB  16
`define SFAC_ST_BUSY      0
`define SFAC_ST_TXE       1
`define SFAC_ST_RXV       2
`define SFAC_ST_ERR       3
`define SFAC_ST_LEFT_LSB  16

// ************************************************************
// Opcodes and fixed bytes
// ************************************************************
`define SFAC_OP_SET_WL    8'h06
`define SFAC_OP_WRITE     8'h02
`define SFAC_OP_READ      8'h03
`define SFAC_OP_QREAD     8'h0B
`define SFAC_OP_SECWR     8'h42
`define SFAC_OP_SECRD     8'h4B
`define SFAC_OP_IDRD      8'h9F
`define SFAC_DUMMY        8'h00
`define SFAC_ID_BYTES     16'h0009
`define SFAC_ARRAY_MASK   24'h0FFFFF
`define SFAC_SECTOR_MASK  24'h0000FF

// ************************************************************
// Reset values and timing
// ************************************************************
`define SFAC_RST_ADDR     24'h000000
`define SFAC_CLK_MHZ      40
`define SFAC_CS_HIGH_NS   60
`define SFAC_SCK_HALF     4

`endif

// File: inc/sfac_pkg.sv
/*
  Types of the serial memory access controller.
  Assumes sfac_params.svh is on the include path.
*/
package sfac_pkg;

  // Command kinds as software writes them into the command register
  typedef enum logic [2:0] {
    SFAC_K_SETWL,
    SFAC_K_WRITE,
    SFAC_K_READ,
    SFAC_K_QREAD,
    SFAC_K_SECWR,
    SFAC_K_SECRD,
    SFAC_K_IDRD,
    SFAC_K_BAD
  } sfac_kind_t;

  typedef enum logic [2:0] {
    SFAC_SQ_IDLE,
    SFAC_SQ_WEN,
    SFAC_SQ_GAP,
    SFAC_SQ_HDR,
    SFAC_SQ_DATA
  } sfac_state_t;

  // One byte handed to the shifter
  typedef struct packed {
    logic       start;
    logic [7:0] data;
  } sfac_byte_req_t;

  // Serial pins driven towards the device
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sfac_pins_t;

endpackage

// File: core/sfac_sync.sv
/*
  Two-flop synchroniser for levels entering from outside the clock domain.
  Assumes the input changes slowly against clk_i.
*/
`timescale 1ns/10ps
module sfac_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

// File: core/sfac_byte_shift.sv
/*
  One-byte SPI mode 0 shifter: eight serial clocks per byte, MSb first.
  Assumes miso_i is already synchronised and the caller holds chip select.
*/
`timescale 1ns/10ps
`include "sfac_params.svh"
module sfac_byte_shift #(
  parameter int unsigned HALF = `SFAC_SCK_HALF
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // Byte request and result
  input  wire sfac_pkg::sfac_byte_req_t req_i,
  output logic                         done_o,
  output logic [7:0]                   rx_o,
  // Serial side
  input  wire logic                    miso_i,
  output logic                         sck_o,
  output logic                         mosi_o
);

  // Two flops of miso sync must settle inside one half period
  if (HALF < 3 || HALF > 255) begin
    $error("sfac_byte_shift: HALF must lie in 3..255");
  end

  localparam logic [7:0] HALF_END = 8'(HALF - 1);

  logic       act_ff, nxt_act;
  logic [7:0] div_ff, nxt_div;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] rx_ff, nxt_rx;
  logic       sck_ff, nxt_sck;
  logic       mosi_ff, nxt_mosi;
  logic       done_ff, nxt_done;

  always_comb begin
    nxt_act  = act_ff;
    nxt_div  = div_ff;
    nxt_bit  = bit_ff;
    nxt_sh   = sh_ff;
    nxt_rx   = rx_ff;
    nxt_sck  = sck_ff;
    nxt_mosi = mosi_ff;
    nxt_done = 1'b0;
    if (!act_ff) begin
      if (req_i.start) begin
        nxt_act  = 1'b1;
        nxt_sh   = req_i.data;
        nxt_mosi = req_i.data[7];
        nxt_bit  = 3'h0;
        nxt_div  = 8'h00;
        nxt_sck  = 1'b0;
      end
    end else if (div_ff == HALF_END) begin
      nxt_div = 8'h00;
      if (!sck_ff) begin
        nxt_sck = 1'b1;
        nxt_rx  = {rx_ff[6:0], miso_i};
      end else begin
        nxt_sck = 1'b0;
        if (bit_ff == 3'h7) begin
          nxt_act  = 1'b0;
          nxt_done = 1'b1;
        end else begin
          nxt_bit  = bit_ff + 3'h1;
          nxt_sh   = {sh_ff[6:0], 1'b0};
          nxt_mosi = sh_ff[6];
        end
      end
    end else begin
      nxt_div = div_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_ff  <= 1'b0;
      div_ff  <= 8'h00;
      bit_ff  <= 3'h0;
      sh_ff   <= 8'h00;
      rx_ff   <= 8'h00;
      sck_ff  <= 1'b0;
      mosi_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      act_ff  <= nxt_act;
      div_ff  <= nxt_div;
      bit_ff  <= nxt_bit;
      sh_ff   <= nxt_sh;
      rx_ff   <= nxt_rx;
      sck_ff  <= nxt_sck;
      mosi_ff <= nxt_mosi;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;
  assign rx_o   = rx_ff;
  assign sck_o  = sck_ff;
  assign mosi_o = mosi_ff;

endmodule

// File: verif/sfac_fram_model.sv
/* Behavioural serial memory on the far side of the host.
   Assumes mode 0 framing from the host. */
`timescale 1ns/10ps
module sfac_fram_model #(
  parameter logic [71:0] ID               = 72'h1122334455667788A5, // Arbitrary value
  parameter logic        block_guard_high = 1'b0,
  parameter logic        block_guard_low  = 1'b0
) (
  // Serial pins
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  output logic      miso_o
);
  // ****************************************
  // Frame state
  // ****************************************
  logic [7:0]  mem [int];
  logic [7:0]  sec [256];
  logic [7:0]  sh, op, ob;
  logic [23:0] adr;
  logic        write_latch_flag = 1'b0;
  logic        drv = 1'b0;
  logic        lock = 1'b0;
  int          bits = 0;
  initial begin
    miso_o = 1'b0;
    foreach (sec[i]) sec[i] = 8'(i) ^ 8'hC3;
  end
  task automatic take(input int n);
    if (n == 0) begin
      op = sh;
      write_latch_flag |= (sh == 8'h06);
    end else if (n < 4) begin
      adr = {adr[15:0], sh};
    end else if (op == 8'h02 && write_latch_flag && !lock) begin
      // Guarded range: counter stops, rest of the frame is dropped
      lock = (block_guard_high & (block_guard_low | adr[19])) |
             (block_guard_low & (&adr[19:18]));
      if (!lock) begin
        mem[adr[19:0]] = sh;
        adr = adr + 24'h1;
      end
    end else if (op == 8'h42 && write_latch_flag) begin
      sec[adr[7:0]] = sh;
      adr = adr + 24'h1;
    end
    drv = 1'b1;
    if (op == 8'h9F && n < 9) ob = ID[8*n +: 8];
    else if (op == 8'h4B && n >= 3) ob = sec[adr[7:0]];
    else if ((op == 8'h03 && n >= 3) || (op == 8'h0B && n >= 4))
      ob = mem.exists(adr[19:0]) ? mem[adr[19:0]] : ~adr[7:0];
    else drv = 1'b0;
    if (drv && op != 8'h9F) adr = adr + 24'h1;
  endtask
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      sh = {sh[6:0], mosi_i};
      bits++;
      if (bits % 8 == 0) take(bits / 8 - 1);
    end
  end
  // Released line flips so a stale bit never passes
  always @(negedge sck_i) begin
    if (!cs_n_i && drv) miso_o <= ob[7 - bits % 8];
    else miso_o <= ~miso_o;
  end
  always @(posedge cs_n_i) begin
    if (op == 8'h02 || op == 8'h42) write_latch_flag = 1'b0;
    bits = 0;
    drv = 1'b0;
    lock = 1'b0;
    miso_o <= ~miso_o;
  end
endmodule

// File: verif/sfac_spi_host_assertions.sv
/* Concurrent checks on the host's bus and serial pins.
   Assumes binding to sfac_spi_host. */
`timescale 1ns/10ps
module sfac_spi_host_assertions #(
  parameter int unsigned SCK_HALF = 4,
  parameter int unsigned AW       = 8
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          reset_i,
  // APB
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic          pready_o,
  input wire logic [31:0]   prdata_o,
  input wire logic          pslverr_o,
  // Serial
  input wire logic          cs_n_o,
  input wire logic          sck_o,
  input wire logic          mosi_o,
  input wire logic          miso_i
);
  logic [7:0] nxt_hi_cnt, hi_cnt_ff;
  always_comb nxt_hi_cnt = sck_o ? hi_cnt_ff + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) hi_cnt_ff <= reset_i ? 8'h00 : nxt_hi_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_enter;
    psel_i && $rose(penable_i);
  endsequence
  sequence s_done;
    pready_o ##1 !pready_o;
  endsequence
  logic bad_a;
  assign bad_a = paddr_i > 8'h10 || paddr_i[1:0] != 2'b00;
  a_ready_wait: assert property (s_enter |-> !pready_o ##1 s_done)
    else $error("ready not one wait state");
  a_err_unmapped: assert property (pready_o && bad_a |-> pslverr_o)
    else $error("no error on unmapped");
  a_err_mapped: assert property (pready_o && !bad_a |-> !pslverr_o)
    else $error("error on mapped");
  a_err_zero: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read not zero");
  a_sck_idle: assert property (cs_n_o |-> !sck_o)
    else $error("clock outside frame");
  a_cs_gap: assert property ($rose(cs_n_o) |-> cs_n_o [*3])
    else $error("select gap short");
  a_mosi_hold: assert property (sck_o |-> $stable(mosi_o))
    else $error("data moved while clock high");
  a_sck_high: assert property ($fell(sck_o) |-> hi_cnt_ff == 8'(SCK_HALF))
    else $error("clock high time wrong");
endmodule
bind sfac_spi_host sfac_spi_host_assertions #(.SCK_HALF(SCK_HALF), .AW(AW)) i_chk (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .cs_n_o(cs_n_o), .sck_o(sck_o),
  .mosi_o(mosi_o), .miso_i(miso_i));

// File: verif/sfac_spi_host_tb_top.sv
/* Self-checking bench: APB master, memory model on the pins.
   Assumes sfac_params.svh on the include path. */
`timescale 1ns/10ps
`include "sfac_params.svh"
module sfac_spi_host_tb_top;
  localparam logic [71:0] ID = 72'h1122334455667788A5; // Arbitrary value
  logic        clk_i = 1'b0, reset_i = 1'b1, err;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, cs_n_o, sck_o, mosi_o, miso_i;
  int          n_fail = 0, checks_done = 0;
  sfac_spi_host #(.SCK_HALF(4), .AW(8)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .cs_n_o(cs_n_o), .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso_i));
  sfac_fram_model #(.ID(ID)) i_mem (.cs_n_i(cs_n_o), .sck_i(sck_o), .mosi_i(mosi_o),
    .miso_o(miso_i));
  initial forever #12.5 clk_i = ~clk_i;
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_st(input int b, input logic v);
    do apb(1'b0, `SFAC_OFS_STAT, 32'h0); while (rd[b] !== v);
  endtask
  task automatic cmd(input logic [2:0] k, input logic [31:0] a, input logic [15:0] n);
    apb(1'b1, `SFAC_OFS_ADDR, a);
    apb(1'b1, `SFAC_OFS_CMD, {n, 13'h0, k});
  endtask
  task automatic tx(input logic [7:0] b);
    wait_st(`SFAC_ST_TXE, 1'b1);
    apb(1'b1, `SFAC_OFS_TXD, {24'h0, b});
  endtask
  task automatic rx(input logic [7:0] b);
    wait_st(`SFAC_ST_RXV, 1'b1);
    apb(1'b0, `SFAC_OFS_RXD, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, b});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_array;
    cmd(3'd1, 32'h00AFFFFE, 16'd3);
    tx(8'hA1);
    tx(8'hB2);
    tx(8'hC3);
    wait_st(`SFAC_ST_BUSY, 1'b0);
    for (int k = 2; k <= 3; k++) begin
      cmd(3'(k), 32'h005FFFFE, 16'd3);
      rx(8'hA1);
      rx(8'hB2);
      rx(8'hC3);
      wait_st(`SFAC_ST_BUSY, 1'b0);
    end
  endtask
  task automatic t_sector;
    cmd(3'd4, 32'h001234FE, 16'd2);
    tx(8'h5A);
    tx(8'h6B);
    wait_st(`SFAC_ST_BUSY, 1'b0);
    cmd(3'd5, 32'h00AB00FE, 16'd2);
    rx(8'h5A);
    rx(8'h6B);
    wait_st(`SFAC_ST_BUSY, 1'b0);
    chk(32'(cs_n_o), 32'h1);
  endtask
  task automatic t_ident;
    cmd(3'd6, 32'h0, 16'd9);
    for (int i = 0; i < 9; i++) rx(ID[8*i +: 8]);
    wait_st(`SFAC_ST_BUSY, 1'b0);
  endtask
  task automatic t_abort;
    cmd(3'd0, 32'h0, 16'd0);
    wait_st(`SFAC_ST_BUSY, 1'b0);
    cmd(3'd2, 32'h000FFFFE, 16'd5);
    rx(8'hA1);
    apb(1'b1, `SFAC_OFS_CMD, 32'h2);
    apb(1'b1, `SFAC_OFS_CMD, 32'h10);
    wait_st(`SFAC_ST_BUSY, 1'b0);
    chk(rd, 32'h0003_000E);
    rx(8'hB2);
    apb(1'b1, `SFAC_OFS_STAT, 32'h8);
  endtask
  task automatic t_refuse;
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, `SFAC_OFS_CMD, 32'h7);
    wait_st(`SFAC_ST_ERR, 1'b1);
    apb(1'b1, `SFAC_OFS_STAT, 32'h8);
    apb(1'b0, `SFAC_OFS_STAT, 32'h0);
    chk(32'(rd[`SFAC_ST_ERR]), 32'h0);
  endtask
  task automatic end_of_test;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk({30'h0, cs_n_o, sck_o}, 32'h2);
    t_array;
    t_sector;
    t_ident;
    t_abort;
    t_refuse;
    end_of_test;
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    end_of_test;
  end
endmodule
